// ---- common/ssr_pkg.sv ----
// Shared constants for the shadowed RAM host controller
package ssr_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 125;
  // Device timing figures, own units
  localparam int T_RC_NS = 300;
  localparam int T_OE_NS = 150;
  localparam int T_WC_NS = 300;
  localparam int T_WP_NS = 200;
  localparam int T_SP_NS = 200;
  localparam int T_RCP_NS = 200;
  localparam int T_RCC_US = 5;
  localparam int T_STC_MS = 10;
  localparam int T_GLITCH_NS = 20;
  localparam int T_SOE_NS = 20;
  // Cycle counts, least times rounded up
  localparam int RD_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
  localparam int OE_CYC = (T_OE_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WC_CYC = (T_WC_NS * CLK_MHZ + 999) / 1000;
  localparam int SP_CYC = (T_SP_NS * CLK_MHZ + 999) / 1000;
  localparam int RCP_CYC = (T_RCP_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_CYC = (T_GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int SOE_CYC = (T_SOE_NS * CLK_MHZ + 999) / 1000;
  localparam int RCC_CYC = T_RCC_US * CLK_MHZ;
  localparam int STC_CYC = T_STC_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 21;
  // Host commands
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_RECALL = 2'h2;
  localparam logic [1:0] CMD_STORE = 2'h3;
  typedef enum logic [5:0] {
    SSR_IDLE = 6'h01,
    SSR_SETUP = 6'h02,
    SSR_STROBE = 6'h04,
    SSR_HOLD = 6'h08,
    SSR_WAIT = 6'h10,
    SSR_PWRUP = 6'h20
  } ssr_state_t;
endpackage : ssr_pkg

// ---- hdl/ssr_timer.sv ----
// Down counter that times the strobe and wait phases of a pin cycle
module ssr_timer #(
  parameter int W = 21
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0) && !load;
endmodule : ssr_timer

// ---- hdl/ssr_host.sv ----
// Host controller driving the shadowed RAM pins
// How it works
// - Nine address bits pick one byte per read or write.
// - Chip select goes low only for read, write, recall or store.
// - A read drives output drive low with write and nv select high.
// - A write drives write strobe low with nv select high.
// - Nv select low with a read strobe recalls, with a write strobe stores.
// - Idle pins keep write strobe and chip select high.
module ssr_host #(
  parameter int RCC_CYCLES = ssr_pkg::RCC_CYC,
  parameter int STC_CYCLES = ssr_pkg::STC_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic [1:0] req_cmd,
  input wire logic [ssr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [ssr_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [ssr_pkg::DATA_W-1:0] rsp_rdata,
  output logic [ssr_pkg::ADDR_W-1:0] word_address,
  output logic chip_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic nonvolatile_select_n,
  input wire logic [ssr_pkg::DATA_W-1:0] data_pins_i,
  output logic [ssr_pkg::DATA_W-1:0] data_pins_o,
  output logic data_pins_oe
);
  localparam int CW = ssr_pkg::CNT_W;
  ssr_pkg::ssr_state_t st_reg, st_next;
  logic [1:0] cmd_reg, cmd_next;
  logic [ssr_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [ssr_pkg::DATA_W-1:0] wdat_reg, wdat_next;
  logic [ssr_pkg::DATA_W-1:0] rdat_reg, rdat_next;
  logic cs_reg, cs_next, oe_reg, oe_next, we_reg, we_next;
  logic ne_reg, ne_next, drv_reg, drv_next, rv_reg, rv_next;
  logic [ssr_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg;
  logic tload, tdone;
  logic [CW-1:0] tval;
  logic boot_reg, boot_next;

  ssr_timer #(.W(CW)) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tload),
    .load_val(tval),
    .done(tdone)
  );

  // Two-stage sampling of the data pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
    end else begin
      din_s1_reg <= data_pins_i;
      din_s2_reg <= din_s1_reg;
    end
  end

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    rdat_next = rdat_reg;
    cs_next = cs_reg;
    oe_next = oe_reg;
    we_next = we_reg;
    ne_next = ne_reg;
    drv_next = drv_reg;
    rv_next = 1'b0;
    tload = 1'b0;
    tval = '0;
    case (st_reg)
      ssr_pkg::SSR_PWRUP: begin
        if (boot_reg) begin
          tload = 1'b1;
          tval = CW'(RCC_CYCLES);
        end else if (tdone) begin
          st_next = ssr_pkg::SSR_IDLE;
        end
      end
      ssr_pkg::SSR_IDLE: begin
        if (req_valid) begin
          cmd_next = req_cmd;
          addr_next = req_addr;
          wdat_next = req_wdata;
          st_next = ssr_pkg::SSR_SETUP;
        end
      end
      ssr_pkg::SSR_SETUP: begin
        cs_next = 1'b0;
        st_next = ssr_pkg::SSR_STROBE;
        tload = 1'b1;
        case (cmd_reg)
          ssr_pkg::CMD_READ: begin
            oe_next = 1'b0;
            tval = CW'(ssr_pkg::RD_CYC);
          end
          ssr_pkg::CMD_WRITE: begin
            we_next = 1'b0;
            drv_next = 1'b1;
            tval = CW'(ssr_pkg::WC_CYC);
          end
          ssr_pkg::CMD_RECALL: begin
            ne_next = 1'b0;
            oe_next = 1'b0;
            tval = CW'(ssr_pkg::RCP_CYC);
          end
          default: begin
            ne_next = 1'b0;
            we_next = 1'b0;
            tval = CW'(ssr_pkg::SP_CYC);
          end
        endcase
      end
      ssr_pkg::SSR_STROBE: begin
        if (tdone) begin
          if (cmd_reg == ssr_pkg::CMD_READ) begin
            rdat_next = din_s2_reg;
            rv_next = 1'b1;
          end
          cs_next = 1'b1;
          oe_next = 1'b1;
          we_next = 1'b1;
          ne_next = 1'b1;
          st_next = ssr_pkg::SSR_HOLD;
        end
      end
      ssr_pkg::SSR_HOLD: begin
        drv_next = 1'b0;
        tload = 1'b1;
        st_next = ssr_pkg::SSR_WAIT;
        if (cmd_reg == ssr_pkg::CMD_RECALL) begin
          tval = CW'(RCC_CYCLES);
        end else if (cmd_reg == ssr_pkg::CMD_STORE) begin
          tval = CW'(STC_CYCLES);
        end else begin
          tval = CW'(ssr_pkg::SOE_CYC);
        end
      end
      ssr_pkg::SSR_WAIT: begin
        if (tdone) begin
          st_next = ssr_pkg::SSR_IDLE;
        end
      end
      default: begin
        st_next = ssr_pkg::SSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ssr_pkg::SSR_PWRUP;
      cmd_reg <= ssr_pkg::CMD_READ;
      addr_reg <= '0;
      wdat_reg <= '0;
      rdat_reg <= '0;
      cs_reg <= 1'b1;
      oe_reg <= 1'b1;
      we_reg <= 1'b1;
      ne_reg <= 1'b1;
      drv_reg <= 1'b0;
      rv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      rdat_reg <= rdat_next;
      cs_reg <= cs_next;
      oe_reg <= oe_next;
      we_reg <= we_next;
      ne_reg <= ne_next;
      drv_reg <= drv_next;
      rv_reg <= rv_next;
    end
  end

  // Power-up wait runs once after reset release
  always_comb begin
    boot_next = 1'b0;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= boot_next;
    end
  end

  assign req_ready = (st_reg == ssr_pkg::SSR_IDLE) && !boot_reg;
  assign rsp_valid = rv_reg;
  assign rsp_rdata = rdat_reg;
  assign word_address = addr_reg;
  assign chip_select_n = cs_reg;
  assign output_drive_n = oe_reg;
  assign write_strobe_n = we_reg;
  assign nonvolatile_select_n = ne_reg;
  assign data_pins_o = wdat_reg;
  assign data_pins_oe = drv_reg;

  property p_store_oe;
    @(posedge core_clk) disable iff (sys_rst)
      (!ne_reg && !we_reg) |-> oe_reg;
  endproperty
  AST_STORE_NO_OE: assert property (p_store_oe)
    else $error("store strobe with output drive low");
  AST_WE_LONG: assert property (@(posedge core_clk)
    disable iff (sys_rst) $fell(we_reg) |-> !we_reg [*3])
    else $error("write strobe too short");
  AST_NV_LONG: assert property (@(posedge core_clk)
    disable iff (sys_rst) $fell(ne_reg) |-> !ne_reg [*3])
    else $error("nv strobe too short");
  AST_READ_PAT: assert property (@(posedge core_clk)
    disable iff (sys_rst) !oe_reg && ne_reg |-> we_reg && !cs_reg)
    else $error("bad read pattern");
  AST_WRITE_DRV: assert property (@(posedge core_clk)
    disable iff (sys_rst) !we_reg && ne_reg |-> drv_reg && !cs_reg)
    else $error("write without data drive");
  AST_NO_DRV_RD: assert property (@(posedge core_clk)
    disable iff (sys_rst) drv_reg |-> oe_reg)
    else $error("bus contention");
  AST_IDLE_PINS: assert property (@(posedge core_clk)
    disable iff (sys_rst) st_reg == ssr_pkg::SSR_IDLE |-> cs_reg && we_reg)
    else $error("pins active in idle");
  AST_BUSY: assert property (@(posedge core_clk)
    disable iff (sys_rst) $fell(ne_reg) |-> !req_ready [*8])
    else $error("request taken during nv op");
  AST_RV_AFTER_READ: assert property (@(posedge core_clk)
    disable iff (sys_rst) rv_reg |-> $past(cmd_reg) == ssr_pkg::CMD_READ)
    else $error("response without read");
  COV_READ: cover property (@(posedge core_clk) rv_reg);
  COV_WRITE: cover property (@(posedge core_clk) $fell(we_reg) && ne_reg);
  COV_STORE: cover property (@(posedge core_clk) !we_reg && !ne_reg);
  COV_RECALL: cover property (@(posedge core_clk) !oe_reg && !ne_reg);
endmodule : ssr_host

// ---- tb/ssr_dev_model.sv ----
// Behavioural model of the shadowed RAM device at its pins
module ssr_dev_model #(
  parameter int REC_BUSY = 15,
  parameter int STO_BUSY = 40
) (
  input wire logic core_clk,
  input wire logic [ssr_pkg::ADDR_W-1:0] word_address,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic nonvolatile_select_n,
  input wire logic [ssr_pkg::DATA_W-1:0] host_data,
  input wire logic host_oe,
  output logic [ssr_pkg::DATA_W-1:0] bus_data,
  output int viol_cnt,
  output int cycled_cnt
);
  logic [7:0] ram [512];
  logic [7:0] nv [512];
  logic [7:0] last_bus;
  logic [7:0] lat_data;
  logic [8:0] lat_addr;
  logic [2:0] lat_mode;
  logic strobe_on;
  logic dev_drive;
  int busy_cnt;
  int pulse_len;

  assign dev_drive = !chip_select_n && !output_drive_n && write_strobe_n &&
    nonvolatile_select_n && busy_cnt == 0;
  // Released bus shows inverse of last value
  assign bus_data = host_oe ? host_data :
    dev_drive ? ram[word_address] : ~last_bus;
  assign strobe_on = !chip_select_n && (!output_drive_n || !write_strobe_n);

  initial begin
    for (int i = 0; i < 512; i++) begin
      nv[i] = 8'h5A ^ i[7:0];
      ram[i] = nv[i];
    end
    busy_cnt = REC_BUSY;
    viol_cnt = 0;
    cycled_cnt = 0;
    pulse_len = 0;
    last_bus = 8'h00;
  end

  task automatic end_pulse;
    int sum;
    sum = 0;
    if (!lat_mode[1] && lat_mode[0]) begin
      if (pulse_len >= ssr_pkg::GLITCH_CYC)
        ram[lat_addr] = lat_data;
    end else if (lat_mode == 3'h4) begin
      if (pulse_len >= ssr_pkg::GLITCH_CYC) begin
        for (int i = 0; i < 512; i++) begin
          sum += $countones(nv[i] ^ ram[i]);
          nv[i] = ram[i];
        end
        cycled_cnt <= cycled_cnt + sum;
        busy_cnt <= STO_BUSY;
      end
    end else if (lat_mode == 3'h2) begin
      for (int i = 0; i < 512; i++)
        ram[i] = nv[i];
      busy_cnt <= REC_BUSY;
    end else if (lat_mode == 3'h0) begin
      viol_cnt <= viol_cnt + 1;
    end
  endtask : end_pulse

  always @(posedge core_clk) begin
    last_bus <= bus_data;
    if (host_oe && dev_drive)
      viol_cnt <= viol_cnt + 1;
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      pulse_len <= 0;
      if (!chip_select_n)
        viol_cnt <= viol_cnt + 1;
    end else if (strobe_on) begin
      pulse_len <= pulse_len + 1;
      lat_addr <= word_address;
      lat_data <= bus_data;
      lat_mode <= {output_drive_n, write_strobe_n, nonvolatile_select_n};
    end else if (pulse_len > 0) begin
      pulse_len <= 0;
      end_pulse();
    end
  end
endmodule : ssr_dev_model

// ---- tb/shadowed_sram_store_recall_test.sv ----
// Self-checking bench for the shadowed RAM host controller
module shadowed_sram_store_recall_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RCC = 20;
  localparam int STC = 50;
  localparam logic [8:0] ADR [4] = '{9'h000, 9'h001, 9'h100, 9'h1FF};
  localparam logic [7:0] IMG [4] = '{8'hFF, 8'h00, 8'h3C, 8'h81};
  logic core_clk, sys_rst, req_valid, req_ready, rsp_valid;
  logic [1:0] req_cmd;
  logic [8:0] req_addr, word_address;
  logic [7:0] req_wdata, rsp_rdata, data_pins_i, data_pins_o;
  logic chip_select_n, output_drive_n, write_strobe_n;
  logic nonvolatile_select_n, data_pins_oe;
  int viol_cnt, cycled_cnt, n_mismatch, check_count;

  ssr_host #(.RCC_CYCLES(RCC), .STC_CYCLES(STC)) u_ssr_host (.core_clk,
    .sys_rst, .req_valid, .req_cmd, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .word_address, .chip_select_n, .output_drive_n,
    .write_strobe_n, .nonvolatile_select_n, .data_pins_i, .data_pins_o,
    .data_pins_oe);
  ssr_dev_model u_ssr_dev_model (.core_clk, .word_address, .chip_select_n,
    .output_drive_n, .write_strobe_n, .nonvolatile_select_n,
    .host_data(data_pins_o), .host_oe(data_pins_oe), .bus_data(data_pins_i),
    .viol_cnt, .cycled_cnt);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic req(input logic [1:0] c, input logic [8:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'h1;
    req_cmd <= c;
    req_addr <= a;
    req_wdata <= d;
    @(negedge core_clk);
    while (req_ready !== 1'h1 && n < 2000) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 2000) n_mismatch++;
    @(posedge core_clk);
    req_valid <= 1'h0;
  endtask : req

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    int n;
    n = 0;
    req(ssr_pkg::CMD_READ, a, 8'h00);
    @(negedge core_clk);
    while (rsp_valid !== 1'h1 && n < 200) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 200) n_mismatch++;
    d = rsp_rdata;
  endtask : rd

  task automatic idle_wait(output int n);
    n = 0;
    @(negedge core_clk);
    while (req_ready !== 1'h1 && n < 5000) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 5000) n_mismatch++;
  endtask : idle_wait

  task automatic t_powerup;
    logic [7:0] d;
    repeat (RCC + 10) @(posedge core_clk);
    rd(9'h003, d);
    check(d, 8'h59);
    rd(9'h1FF, d);
    check(d, 8'hA5);
  endtask : t_powerup

  task automatic t_rw;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
      req(ssr_pkg::CMD_WRITE, ADR[i], IMG[i]);
    for (int i = 0; i < 4; i++) begin
      rd(ADR[i], d);
      check(d, IMG[i]);
    end
    repeat (60) @(negedge core_clk);
    check(chip_select_n, 1'h1);
    check(write_strobe_n, 1'h1);
  endtask : t_rw

  task automatic t_store_recall;
    logic [7:0] d;
    int n, c0, exp;
    exp = 0;
    for (int i = 0; i < 4; i++)
      exp += $countones(IMG[i] ^ (8'h5A ^ ADR[i][7:0]));
    c0 = cycled_cnt;
    req(ssr_pkg::CMD_STORE, 9'h000, 8'h00);
    idle_wait(n);
    check(n >= STC, 1'h1);
    check(cycled_cnt - c0, exp);
    req(ssr_pkg::CMD_WRITE, ADR[2], 8'hC3);
    req(ssr_pkg::CMD_RECALL, 9'h000, 8'h00);
    idle_wait(n);
    check(n >= RCC, 1'h1);
    rd(ADR[2], d);
    check(d, IMG[2]);
    c0 = cycled_cnt;
    req(ssr_pkg::CMD_STORE, 9'h1FF, 8'h00);
    idle_wait(n);
    check(cycled_cnt - c0, 0);
  endtask : t_store_recall

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    sys_rst = 1'h1;
    req_valid = 1'h0;
    req_cmd = 2'h0;
    req_addr = 9'h000;
    req_wdata = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_powerup();
    t_rw();
    t_store_recall();
    check(viol_cnt, 0);
    test_done();
  end
endmodule : shadowed_sram_store_recall_test
